// *** verilog/sfpe_pkg.sv ***
// Summary of operation
// (R1) Quad output wide read: always 32-bit address
// (R2) Dual I/O read: address on IO0/IO1
// (R3) Dual I/O read: four ignored dummy clocks
// (R4) Host releases IO0 before first output
// (R5) Quad I/O read: four lanes, six dummies
// (R6) Wide dual/quad I/O reads: 32-bit address
// (R7) Dual I/O address width follows mode
// (R8) Program one to 256 bytes, one page
// (R9) Program refused unless write latch set
// (R10) Host frames opcode, address, data, CS low
// (R11) Program data wraps within page
// (R12) Over 256 bytes overwrite earlier bytes
// (R13) Execute only on byte-aligned CS rise
// (R14) Valid program starts self-timed busy cycle
// (R15) Status reads answered while busy
// (R16) Protected pages are not programmed
// (R17) Each die keeps its own busy flag
// (R18) Quad program takes address, data on four
// (R19) Wide program variants: 32-bit address
// (R20) Sector erase sets 4 KB to FFh
// (R21) Erase end clears busy and write latch
// (R22) Protected sectors are not erased
// (R23) Upper address byte: instruction or extension
// (R24) Sample on rise, shift out on fall
// (R25) Program/erase opcodes ignored while busy
package sfpe_pkg;
  localparam logic [7:0] OP_QOUT_RD = 8'h6B;
  localparam logic [7:0] OP_QOUT_RD4 = 8'h6C;
  localparam logic [7:0] OP_DIO_RD = 8'hBB;
  localparam logic [7:0] OP_DIO_RD4 = 8'hBC;
  localparam logic [7:0] OP_QIO_RD = 8'hEB;
  localparam logic [7:0] OP_QIO_RD4 = 8'hEC;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG4 = 8'h12;
  localparam logic [7:0] OP_QPROG = 8'h32;
  localparam logic [7:0] OP_QPROG4 = 8'h34;
  localparam logic [7:0] OP_SERASE = 8'h20;
  localparam logic [7:0] OP_SERASE4 = 8'h21;
  localparam logic [7:0] OP_STATUS = 8'h05;
  localparam logic [3:0] DUMMY_DIO = 4'h4;
  localparam logic [3:0] DUMMY_QIO = 4'h6;
  localparam logic [3:0] DUMMY_QOUT = 4'h8;
  localparam logic [3:0] DUMMY_NONE = 4'h0;
  localparam logic [2:0] LANE1 = 3'h1;
  localparam logic [2:0] LANE2 = 3'h2;
  localparam logic [2:0] LANE4 = 3'h4;
  localparam logic [5:0] ABITS3 = 6'h18;
  localparam logic [5:0] ABITS4 = 6'h20;
  localparam int DIE_AW = 25;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [11:0] SECTOR_LAST = 12'hFFF;
  localparam logic [7:0] PAGE_LAST = 8'hFF;
  localparam logic [3:0] BP_WHOLE = 4'hA;
  localparam int BP_BASE_SHIFT = 15;
  localparam int CLK_PERIOD_NS = 10;
  typedef enum logic [6:0] {
    F_OPC = 7'h01, F_ADDR = 7'h02, F_DUMMY = 7'h04, F_DIN = 7'h08,
    F_DOUT = 7'h10, F_DONE = 7'h20, F_SKIP = 7'h40
  } sfpe_frame_t;
  typedef enum logic [3:0] {
    E_IDLE = 4'h1, E_PROG = 4'h2, E_ERASE = 4'h4, E_WAIT = 4'h8
  } sfpe_exec_t;
  typedef enum logic [2:0] {
    K_NONE = 3'h0, K_READ = 3'h1, K_PROG = 3'h2, K_ERASE = 3'h3, K_STAT = 3'h4
  } sfpe_kind_t;
  typedef struct packed {
    sfpe_kind_t kind;
    logic [2:0] alane;
    logic wide;
    logic [3:0] dummy;
    logic [2:0] dlane;
  } sfpe_cmd_t;
  typedef struct packed {
    logic cmp;
    logic tb;
    logic [3:0] bp;
  } sfpe_protect_t;
  typedef struct packed {
    logic we;
    logic [DIE_AW-1:0] addr;
    logic [7:0] data;
  } sfpe_mem_wr_t;
endpackage

// *** verilog/sfpe_core.sv ***
`timescale 1ns/100ps
module sfpe_core #(
  parameter int PROG_TIME_NS = 100000,
  parameter int ERASE_TIME_NS = 1000000
) (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic sclk_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  input wire logic wide_address_mode_flag_in,
  input wire logic [7:0] ext_addr_in,
  input wire logic write_permit_set_in,
  input wire sfpe_pkg::sfpe_protect_t protect_in,
  input wire logic lock_hit_in,
  output logic write_permit_latch_out,
  output logic busy_out,
  output logic [sfpe_pkg::DIE_AW-1:0] mem_rd_addr_out,
  input wire logic [7:0] mem_rd_data_in,
  output sfpe_pkg::sfpe_mem_wr_t mem_wr_out
);
  import sfpe_pkg::*;

  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Two-flop synchronisers for the pins; SCLK must stay well below a quarter of clk_sys
  logic [6:0] pin_meta_ff;
  logic [6:0] pin_sync_ff;
  logic cs_prev_ff;
  logic sclk_prev_ff;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      // Idle levels: select high, clock parked low, so no false edge follows reset
      pin_meta_ff <= 7'h01;
      pin_sync_ff <= 7'h01;
      cs_prev_ff <= 1'b1;
      sclk_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= {io_in, 1'b0, sclk_in, cs_b_in};
      pin_sync_ff <= pin_meta_ff;
      cs_prev_ff <= pin_sync_ff[0];
      sclk_prev_ff <= pin_sync_ff[1];
    end
  end

  logic cs_low;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic [3:0] io_s;
  assign cs_low = ~pin_sync_ff[0];
  assign cs_rise = pin_sync_ff[0] & ~cs_prev_ff;
  assign sclk_rise = pin_sync_ff[1] & ~sclk_prev_ff & cs_low; // R24
  assign sclk_fall = ~pin_sync_ff[1] & sclk_prev_ff & cs_low; // R24
  assign io_s = pin_sync_ff[6:3];

  // Opcode decode into lanes, address width and dummy count
  function automatic sfpe_cmd_t decode(input logic [7:0] op);
    sfpe_cmd_t c;
    c = '{K_NONE, LANE1, 1'b0, DUMMY_NONE, LANE1};
    unique case (op)
      OP_QOUT_RD: c = '{K_READ, LANE1, 1'b0, DUMMY_QOUT, LANE4};
      OP_QOUT_RD4: c = '{K_READ, LANE1, 1'b1, DUMMY_QOUT, LANE4}; // R1
      OP_DIO_RD: c = '{K_READ, LANE2, 1'b0, DUMMY_DIO, LANE2}; // R2 R3 R7
      OP_DIO_RD4: c = '{K_READ, LANE2, 1'b1, DUMMY_DIO, LANE2}; // R6
      OP_QIO_RD: c = '{K_READ, LANE4, 1'b0, DUMMY_QIO, LANE4}; // R5
      OP_QIO_RD4: c = '{K_READ, LANE4, 1'b1, DUMMY_QIO, LANE4}; // R6
      OP_PROG: c = '{K_PROG, LANE1, 1'b0, DUMMY_NONE, LANE1};
      OP_PROG4: c = '{K_PROG, LANE1, 1'b1, DUMMY_NONE, LANE1}; // R19
      OP_QPROG: c = '{K_PROG, LANE4, 1'b0, DUMMY_NONE, LANE4}; // R18
      OP_QPROG4: c = '{K_PROG, LANE4, 1'b1, DUMMY_NONE, LANE4}; // R19
      OP_SERASE: c = '{K_ERASE, LANE1, 1'b0, DUMMY_NONE, LANE1};
      OP_SERASE4: c = '{K_ERASE, LANE1, 1'b1, DUMMY_NONE, LANE1};
      OP_STATUS: c = '{K_STAT, LANE1, 1'b0, DUMMY_NONE, LANE1};
      default: c = '{K_NONE, LANE1, 1'b0, DUMMY_NONE, LANE1};
    endcase
    return c;
  endfunction

  // Shift the sampled lanes in, IO3 or IO1 carrying the higher bit
  function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] io,
                                           input logic [2:0] lanes);
    logic [31:0] r;
    r = {sh[30:0], io[0]};
    if (lanes == LANE2) begin
      r = {sh[29:0], io[1:0]};
    end else if (lanes == LANE4) begin
      r = {sh[27:0], io};
    end
    return r;
  endfunction

  // Clocks needed for a given bit count on a given lane width
  function automatic logic [5:0] clocks(input logic [5:0] bits, input logic [2:0] lanes);
    logic [5:0] r;
    r = bits;
    if (lanes == LANE2) begin
      r = bits >> 1;
    end else if (lanes == LANE4) begin
      r = bits >> 2;
    end
    return r;
  endfunction

  // Block protect decode; the region doubles per range step, complement inverts it
  function automatic logic is_protected(input sfpe_protect_t p, input logic [DIE_AW-1:0] a);
    logic [DIE_AW:0] lim;
    logic hit;
    lim = '0;
    hit = 1'b0;
    if (p.bp >= BP_WHOLE) begin
      hit = 1'b1;
    end else if (p.bp != 4'h0) begin
      lim = (DIE_AW+1)'(1) << (BP_BASE_SHIFT + int'(p.bp));
      hit = p.tb ? ({1'b0, a} < lim) : ({1'b0, a} >= ((DIE_AW+1)'(1) << DIE_AW) - lim);
    end
    return hit ^ p.cmp;
  endfunction

  sfpe_frame_t frame_ff;
  sfpe_cmd_t cmd_ff;
  logic [31:0] sh_ff;
  logic [5:0] cnt_ff;
  logic [5:0] len_ff;
  logic [31:0] addr_ff;
  logic [7:0] idx_ff;
  logic got_byte_ff;
  logic [7:0] page_mem [0:255];
  logic [255:0] valid_ff;
  logic [7:0] ob_ff;
  logic [3:0] opos_ff;
  sfpe_exec_t exec_ff;
  logic busy_ff;
  logic wel_ff;
  logic [31:0] op_addr_ff;
  logic [11:0] ecnt_ff;
  logic [31:0] timer_ff;
  logic [3:0] io_ff;
  logic [3:0] oe_ff;
  logic [DIE_AW-1:0] rd_addr_ff;

  sfpe_cmd_t dec;
  logic [31:0] sh_next;
  logic [31:0] addr_full;
  logic [7:0] out_byte;
  logic [3:0] chunks;
  assign dec = decode({sh_ff[6:0], io_s[0]});
  assign sh_next = shift_in(sh_ff, io_s, (frame_ff == F_DIN) ? cmd_ff.dlane : cmd_ff.alane);
  // R23: 3-byte frames borrow the upper byte from the extension register
  assign addr_full = (len_ff == clocks(ABITS4, cmd_ff.alane)) ? sh_next :
                     {ext_addr_in, sh_next[23:0]};
  assign out_byte = (cmd_ff.kind == K_STAT) ? {7'h00, busy_ff} : mem_rd_data_in; // R15
  assign chunks = 4'(8 / int'(cmd_ff.dlane));

  // Frame sequencer, advanced on each sampled SCLK rise
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || !cs_low) begin
      frame_ff <= F_OPC;
      cmd_ff <= '{K_NONE, LANE1, 1'b0, DUMMY_NONE, LANE1};
      sh_ff <= 32'h0000_0000;
      cnt_ff <= 6'h00;
      len_ff <= 6'h00;
      if (!rst_b_in) begin
        addr_ff <= 32'h0000_0000;
        idx_ff <= 8'h00;
        got_byte_ff <= 1'b0;
        rd_addr_ff <= '0;
      end
    end else if (sclk_rise) begin
      sh_ff <= sh_next;
      cnt_ff <= cnt_ff + 6'h01;
      unique case (frame_ff)
        F_OPC: begin
          if (cnt_ff == 6'h07) begin
            cmd_ff <= dec;
            cnt_ff <= 6'h00;
            got_byte_ff <= 1'b0;
            len_ff <= clocks((dec.wide || wide_address_mode_flag_in) ? ABITS4 : ABITS3,
                             dec.alane); // R1 R6 R7 R19
            if (dec.kind == K_STAT) begin
              frame_ff <= F_DOUT;
            end else if (dec.kind == K_NONE || busy_ff) begin
              frame_ff <= F_SKIP; // R25
            end else if (dec.kind != K_READ && !wel_ff) begin
              frame_ff <= F_SKIP; // R9
            end else begin
              frame_ff <= F_ADDR;
            end
          end
        end
        F_ADDR: begin
          if (cnt_ff == len_ff - 6'h01) begin
            cnt_ff <= 6'h00;
            addr_ff <= addr_full;
            idx_ff <= addr_full[7:0];
            rd_addr_ff <= addr_full[DIE_AW-1:0];
            if (cmd_ff.kind == K_PROG) begin
              frame_ff <= F_DIN;
            end else if (cmd_ff.kind == K_ERASE) begin
              frame_ff <= F_DONE;
            end else begin
              frame_ff <= F_DUMMY;
            end
          end
        end
        F_DUMMY: begin
          // Line values are ignored here
          if (cnt_ff == {2'b00, cmd_ff.dummy} - 6'h01) begin
            frame_ff <= F_DOUT; // R3 R5
          end
        end
        F_DIN: begin
          if (cnt_ff == {2'b00, chunks} - 6'h01) begin
            cnt_ff <= 6'h00;
            got_byte_ff <= 1'b1;
            idx_ff <= idx_ff + 8'h01; // R11 R12
          end
        end
        F_DONE: frame_ff <= F_SKIP; // R13
        F_DOUT: frame_ff <= F_DOUT;
        F_SKIP: frame_ff <= F_SKIP;
      endcase
    end else if (sclk_fall && frame_ff == F_DOUT && cmd_ff.kind == K_READ &&
                 opos_ff == chunks - 4'h1) begin
      rd_addr_ff <= rd_addr_ff + DIE_AW'(1);
    end
  end

  // Page buffer; a later byte at the same index replaces the earlier one
  always_ff @(posedge clk_sys_in) begin
    if (sclk_rise && frame_ff == F_DIN && cnt_ff == {2'b00, chunks} - 6'h01) begin
      page_mem[idx_ff] <= sh_next[7:0]; // R8 R12
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      valid_ff <= '0;
    end else if (sclk_rise && frame_ff == F_OPC && cnt_ff == 6'h07 && !busy_ff) begin
      valid_ff <= '0;
    end else if (sclk_rise && frame_ff == F_DIN && cnt_ff == {2'b00, chunks} - 6'h01) begin
      valid_ff[idx_ff] <= 1'b1;
    end
  end

  // Output shifter on SCLK fall; IO0 is driven only in the data phase
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in || !cs_low || frame_ff != F_DOUT) begin
      ob_ff <= 8'h00;
      opos_ff <= 4'h0;
      io_ff <= 4'h0;
      oe_ff <= 4'h0;
    end else if (sclk_fall) begin // R24
      logic [7:0] b;
      b = (opos_ff == 4'h0) ? out_byte : ob_ff;
      opos_ff <= (opos_ff == chunks - 4'h1) ? 4'h0 : opos_ff + 4'h1;
      unique case (cmd_ff.dlane)
        LANE2: begin
          io_ff <= {2'b00, b[7:6]};
          oe_ff <= 4'h3; // R2 R4
          ob_ff <= {b[5:0], 2'b00};
        end
        LANE4: begin
          io_ff <= b[7:4];
          oe_ff <= 4'hF; // R5
          ob_ff <= {b[3:0], 4'h0};
        end
        default: begin
          io_ff <= {2'b00, b[7], 1'b0};
          oe_ff <= 4'h2;
          ob_ff <= {b[6:0], 1'b0};
        end
      endcase
    end
  end

  // Self-timed program and erase engine
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      exec_ff <= E_IDLE;
      busy_ff <= 1'b0;
      op_addr_ff <= 32'h0000_0000;
      ecnt_ff <= 12'h000;
      timer_ff <= 32'h0000_0000;
      mem_wr_out <= '0;
    end else begin
      mem_wr_out.we <= 1'b0;
      unique case (exec_ff)
        E_IDLE: begin
          ecnt_ff <= 12'h000;
          op_addr_ff <= addr_ff;
          if (cs_rise && !is_protected(protect_in, addr_ff[DIE_AW-1:0]) && !lock_hit_in) begin
            if (frame_ff == F_DIN && cnt_ff == 6'h00 && got_byte_ff) begin // R13 R16
              exec_ff <= E_PROG;
              busy_ff <= 1'b1; // R14 R17
              timer_ff <= 32'(PROG_CYC);
            end else if (frame_ff == F_DONE) begin // R13 R22
              exec_ff <= E_ERASE;
              busy_ff <= 1'b1;
              timer_ff <= 32'(ERASE_CYC);
            end
          end
        end
        E_PROG: begin
          // Only bytes that arrived are written, others keep their content
          mem_wr_out.we <= valid_ff[ecnt_ff[7:0]];
          mem_wr_out.addr <= {op_addr_ff[DIE_AW-1:8], ecnt_ff[7:0]};
          mem_wr_out.data <= page_mem[ecnt_ff[7:0]];
          ecnt_ff <= ecnt_ff + 12'h001;
          if (ecnt_ff[7:0] == PAGE_LAST) begin
            exec_ff <= E_WAIT;
          end
        end
        E_ERASE: begin
          mem_wr_out.we <= 1'b1;
          mem_wr_out.addr <= {op_addr_ff[DIE_AW-1:12], ecnt_ff};
          mem_wr_out.data <= ERASED_BYTE; // R20
          ecnt_ff <= ecnt_ff + 12'h001;
          if (ecnt_ff == SECTOR_LAST) begin
            exec_ff <= E_WAIT;
          end
        end
        E_WAIT: begin
          timer_ff <= timer_ff - 32'h0000_0001;
          if (timer_ff <= 32'h0000_0001) begin
            exec_ff <= E_IDLE;
            busy_ff <= 1'b0; // R14 R21
          end
        end
        default: exec_ff <= E_IDLE;
      endcase
    end
  end

  // Write permit latch; a set in the cycle of the clear wins
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wel_ff <= 1'b0;
    end else if (write_permit_set_in) begin
      wel_ff <= 1'b1;
    end else if (exec_ff == E_WAIT && timer_ff <= 32'h0000_0001) begin
      wel_ff <= 1'b0; // R21
    end
  end

  assign io_out = io_ff;
  assign io_oe_out = oe_ff;
  assign busy_out = busy_ff;
  assign write_permit_latch_out = wel_ff;
  assign mem_rd_addr_out = rd_addr_ff;
endmodule

// *** bench/sfpe_host_model.sv ***
`timescale 1ns/100ps
module sfpe_host_model (
  input wire logic clk_in,
  input wire logic [3:0] io_in,
  output logic cs_b_out,
  output logic sclk_out,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out
);
  // Idle: deselected, clock parked low, lines released
  initial begin
    cs_b_out = 1'b1;
    sclk_out = 1'b0;
    io_out = 4'h0;
    io_oe_out = 4'h0;
  end
  // Eight system cycles per level, well above the synchroniser limit
  task automatic half();
    repeat (8) @(negedge clk_in);
  endtask
  task automatic start();
    cs_b_out = 1'b0;
    half();
  endtask
  // Bits change while the clock is low, top lane carries the higher bit
  task automatic send(input logic [31:0] v, input int nbits, input int lanes);
    io_oe_out = (lanes == 4) ? 4'hF : (lanes == 2) ? 4'h3 : 4'h1;
    for (int i = nbits - lanes; i >= 0; i -= lanes) begin
      io_out = 4'h0;
      for (int k = 0; k < lanes; k++) io_out[k] = v[i + k];
      half();
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
    end
  endtask
  // Lines released first, so dummies see only noise; sample just before rise
  task automatic recv(input int nbits, input int lanes, output logic [31:0] v);
    io_oe_out = 4'h0;
    v = '0;
    for (int i = 0; i < nbits; i += lanes) begin
      half();
      if (lanes == 1) v = {v[30:0], io_in[1]};
      else if (lanes == 2) v = {v[29:0], io_in[1:0]};
      else v = {v[27:0], io_in};
      sclk_out = 1'b1;
      half();
      sclk_out = 1'b0;
    end
  endtask
  // Rise of select only after the last full clock
  task automatic stop();
    half();
    io_oe_out = 4'h0;
    cs_b_out = 1'b1;
    half();
    half();
  endtask
endmodule

// *** bench/sfpe_core_assertions.sv ***
`timescale 1ns/100ps
module sfpe_core_checker (
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic cs_b_in,
  input wire logic sclk_in,
  input wire logic write_permit_set_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe_out,
  input wire logic write_permit_latch_out,
  input wire logic busy_out,
  input wire sfpe_pkg::sfpe_mem_wr_t mem_wr_out
);
  import sfpe_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // Cycle ownership and latch handling
  a_busy_needs_latch: assert property (busy_out |-> write_permit_latch_out)
    else $error("busy without write permit");
  a_end_clears_latch: assert property ($fell(busy_out) &&
    !$past(write_permit_set_in) |-> !write_permit_latch_out)
    else $error("latch kept after cycle end");
  a_write_while_busy: assert property (mem_wr_out.we |-> busy_out)
    else $error("array write outside cycle");
  a_busy_after_cs: assert property ($rose(busy_out) |-> cs_b_in && $past(cs_b_in))
    else $error("cycle started while selected");
  a_busy_holds_on: assert property ($rose(busy_out) |=> busy_out [*8])
    else $error("busy pulse too short");
  // Pin behaviour
  a_quiet_unselected: assert property (cs_b_in [*6] |-> io_oe_out == 4'h0)
    else $error("driving while deselected");
  a_shift_on_fall: assert property ($changed(io_out) |-> !sclk_in)
    else $error("output moved while clock high");
  a_status_only_busy: assert property (busy_out |->
    io_oe_out[3:2] == 2'h0 && !io_oe_out[0])
    else $error("read answered while busy");
  // Consecutive writes of one cycle stay in one sector
  a_sector_stays: assert property (mem_wr_out.we && $past(mem_wr_out.we)
    |-> mem_wr_out.addr[24:12] == $past(mem_wr_out.addr[24:12]))
    else $error("write run left its sector");
  c_cycle_done: cover property ($fell(busy_out));
  c_quad_out: cover property (io_oe_out == 4'hF);
  c_dual_out: cover property (io_oe_out == 4'h3);
  c_busy_poll: cover property (busy_out && io_oe_out[1]);
endmodule
bind sfpe_core sfpe_core_checker sfpe_core_checker_inst (.clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in), .cs_b_in(cs_b_in), .sclk_in(sclk_in),
  .write_permit_set_in(write_permit_set_in), .io_out(io_out), .io_oe_out(io_oe_out),
  .write_permit_latch_out(write_permit_latch_out), .busy_out(busy_out),
  .mem_wr_out(mem_wr_out));

// *** bench/tb_sfpe_core.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; \
  if ((got) !== (ex)) begin \
    $display("ERROR %s expected %h seen %h", nm, ex, got); \
    n_mismatch++; \
  end \
end
module tb_sfpe_core;
  import sfpe_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic mode_in = 1'b0;
  logic [7:0] ext_in = 8'h00;
  logic set_in = 1'b0;
  sfpe_protect_t prot_in = '0;
  logic lock_in = 1'b0;
  logic cs_b, sclk, busy, latch;
  logic [3:0] h_io, h_oe, d_io, d_oe, pin_io;
  logic [3:0] flt = 4'h5;
  logic [DIE_AW-1:0] rd_addr;
  sfpe_mem_wr_t wr;
  int n_mismatch = 0;
  int samples_checked = 0;
  int wr_cnt = 0;
  int ff = 0;
  logic [7:0] wmem [int];
  logic [31:0] v;
  always #5 clk_sys_in = ~clk_sys_in;
  // Released lines toggle so a stale value can never pass for data
  always @(posedge clk_sys_in) flt <= ~flt;
  assign pin_io = (d_oe & d_io) | (~d_oe & h_oe & h_io) | (~d_oe & ~h_oe & flt);
  // Array model: content is a hash of the address
  function automatic logic [7:0] memv(input logic [DIE_AW-1:0] a);
    return a[7:0] ^ a[23:16] ^ {7'h00, a[24]};
  endfunction
  always @(posedge clk_sys_in) if (wr.we === 1'b1) begin
    wr_cnt++;
    wmem[int'(wr.addr)] = wr.data;
  end
  sfpe_core #(.PROG_TIME_NS(100), .ERASE_TIME_NS(200)) sfpe_core_inst (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .cs_b_in(cs_b), .sclk_in(sclk),
    .io_in(pin_io), .io_out(d_io), .io_oe_out(d_oe), .wide_address_mode_flag_in(mode_in),
    .ext_addr_in(ext_in), .write_permit_set_in(set_in), .protect_in(prot_in),
    .lock_hit_in(lock_in), .write_permit_latch_out(latch), .busy_out(busy),
    .mem_rd_addr_out(rd_addr), .mem_rd_data_in(memv(rd_addr)), .mem_wr_out(wr));
  sfpe_host_model sfpe_host_model_inst (.clk_in(clk_sys_in), .io_in(pin_io),
    .cs_b_out(cs_b), .sclk_out(sclk), .io_out(h_io), .io_oe_out(h_oe));
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic set_latch();
    set_in = 1'b1;
    tick(1);
    set_in = 1'b0;
  endtask
  // Bounded wait for the self-timed cycle
  task automatic wait_idle();
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) tick(1);
    `CHK("idle wait", 1'b0, busy)
  endtask
  // Read frame: opcode, address, dummies, two bytes
  task automatic rd(input logic [7:0] op, input int al, input int ab, input int dm,
                    input int dl, input logic [31:0] a, input logic [DIE_AW-1:0] ea);
    sfpe_host_model_inst.start();
    sfpe_host_model_inst.send({24'h0, op}, 8, 1);
    sfpe_host_model_inst.send(a, ab, al);
    sfpe_host_model_inst.recv(dm, 1, v);
    sfpe_host_model_inst.recv(16, dl, v);
    sfpe_host_model_inst.stop();
    `CHK("read data", {memv(ea), memv(ea + DIE_AW'(1))}, v[15:0])
  endtask
  // Program or erase frame; xb adds a trailing partial byte
  task automatic pg(input logic [7:0] op, input int al, input int ab, input logic [31:0] a,
                    input int nb, input int dl, input int xb);
    sfpe_host_model_inst.start();
    sfpe_host_model_inst.send({24'h0, op}, 8, 1);
    sfpe_host_model_inst.send(a, ab, al);
    for (int n = 0; n < nb; n++) sfpe_host_model_inst.send({24'h0, n[8], n[6:0]}, 8, dl);
    if (xb > 0) sfpe_host_model_inst.send(32'h0, xb, 1);
    sfpe_host_model_inst.stop();
    tick(8);
  endtask
  task automatic status();
    sfpe_host_model_inst.start();
    sfpe_host_model_inst.send({24'h0, OP_STATUS}, 8, 1);
    sfpe_host_model_inst.recv(8, 1, v);
    sfpe_host_model_inst.stop();
  endtask
  task automatic print_verdict();
    $display("Mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Watchdog sized well past the whole sequence
  initial begin
    tick(60000);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    tick(4);
    rst_b_in = 1'b1;
    tick(3);
    `CHK("busy", 1'b0, busy)
    ext_in = 8'h01;
    rd(OP_DIO_RD, 2, 24, 4, 2, 32'h00123456, 25'h1123456);
    mode_in = 1'b1;
    rd(OP_DIO_RD, 2, 32, 4, 2, 32'h00ABCDE0, 25'h0ABCDE0);
    mode_in = 1'b0;
    rd(OP_DIO_RD4, 2, 32, 4, 2, 32'h01000F00, 25'h1000F00);
    rd(OP_QIO_RD, 4, 24, 6, 4, 32'h00004321, 25'h1004321);
    rd(OP_QIO_RD4, 4, 32, 6, 4, 32'h00FF00FF, 25'h0FF00FF);
    rd(OP_QOUT_RD4, 1, 32, 8, 4, 32'h00777777, 25'h0777777);
    rd(OP_QOUT_RD, 1, 24, 8, 4, 32'h00001234, 25'h1001234);
    ext_in = 8'h00;
    pg(OP_PROG, 1, 24, 32'h0010FE, 3, 1, 0);
    `CHK("refused busy", 1'b0, busy)
    set_latch();
    pg(OP_PROG, 1, 24, 32'h0010FE, 3, 1, 0);
    `CHK("prog busy", 1'b1, busy)
    wait_idle();
    `CHK("prog count", 3, wr_cnt)
    `CHK("wrap byte", 8'h02, wmem[32'h1000])
    `CHK("first byte", 8'h00, wmem[32'h10FE])
    `CHK("latch after prog", 1'b0, latch)
    set_latch();
    pg(OP_PROG, 1, 24, 32'h001100, 1, 1, 3);
    `CHK("partial busy", 1'b0, busy)
    wr_cnt = 0;
    pg(OP_QPROG4, 4, 32, 32'h00002000, 258, 4, 0);
    `CHK("quad busy", 1'b1, busy)
    wait_idle();
    `CHK("quad count", 256, wr_cnt)
    `CHK("overwrite 0", 8'h80, wmem[32'h2000])
    `CHK("overwrite 1", 8'h81, wmem[32'h2001])
    `CHK("last byte", 8'h7F, wmem[32'h20FF])
    set_latch();
    lock_in = 1'b1;
    pg(OP_SERASE, 1, 24, 32'h003456, 0, 1, 0);
    `CHK("locked busy", 1'b0, busy)
    `CHK("locked latch", 1'b1, latch)
    lock_in = 1'b0;
    wr_cnt = 0;
    pg(OP_SERASE, 1, 24, 32'h003456, 0, 1, 0);
    `CHK("erase busy", 1'b1, busy)
    status();
    `CHK("status busy", 8'h01, v[7:0])
    pg(OP_PROG, 1, 24, 32'h004000, 1, 1, 0);
    wait_idle();
    `CHK("erase count", 4096, wr_cnt)
    for (int i = 32'h3000; i < 32'h4000; i++) begin
      if (wmem.exists(i) && wmem[i] === ERASED_BYTE) begin
        ff++;
      end
    end
    `CHK("erased bytes", 4096, ff)
    `CHK("ignored prog", 0, wmem.exists(32'h4000))
    `CHK("latch after erase", 1'b0, latch)
    status();
    `CHK("status idle", 8'h00, v[7:0])
    set_latch();
    prot_in.bp = BP_WHOLE;
    pg(OP_PROG, 1, 24, 32'h000100, 1, 1, 0);
    `CHK("protected busy", 1'b0, busy)
    // Remaining opcodes: quad 3-byte program, wide erase, wide single-line program
    prot_in = '0;
    wr_cnt = 0;
    pg(OP_QPROG, 4, 24, 32'h005010, 2, 4, 0);
    wait_idle();
    `CHK("quad 24 count", 2, wr_cnt)
    `CHK("quad 24 byte", 8'h01, wmem[32'h5011])
    set_latch();
    pg(OP_SERASE4, 1, 32, 32'h00005010, 0, 1, 0);
    `CHK("wide erase busy", 1'b1, busy)
    wait_idle();
    `CHK("wide erase byte", ERASED_BYTE, wmem[32'h5011])
    set_latch();
    pg(OP_PROG4, 1, 32, 32'h01006000, 1, 1, 0);
    wait_idle();
    `CHK("wide prog byte", 8'h00, wmem[32'h1006000])
    print_verdict();
  end
endmodule
